//--- design/ocf_pkg.sv
package ocf_pkg;
    // ==========================================
    // Command codes and layouts
    localparam logic [7:0] OCF_CMD_LV_ACTION = 8'h49;
    localparam logic [7:0] OCF_CMD_WARN_THR = 8'h4a;
    localparam int OCF_BIT_NOT_IGNORED = 6;
    localparam int OCF_BIT_RETRY_HI = 5;
    localparam int OCF_BIT_RETRY_LO = 3;
    localparam int OCF_BIT_DELAY_HI = 2;
    localparam int OCF_WARN_MANT_W = 6;
    localparam logic [2:0] OCF_RETRY_LATCH = 3'h0;
    localparam logic [2:0] OCF_RETRY_HICCUP = 3'h7;
    // ==========================================
    // Reset values
    localparam logic [7:0] OCF_LV_ACTION_RST = 8'h40;
    localparam logic [5:0] OCF_WARN_MANT_RST = 6'h3f;
    // ==========================================
    // Timing
    localparam int OCF_CLK_MHZ = 100;
    localparam int OCF_DLY0_US = 2;
    localparam int OCF_DLY1_US = 16;
    localparam int OCF_DLY2_US = 64;
    localparam int OCF_DLY3_US = 256;
    localparam int OCF_HICCUP_MS = 52;
    localparam int OCF_DLY0_CYC = OCF_DLY0_US * OCF_CLK_MHZ;
    localparam int OCF_DLY1_CYC = OCF_DLY1_US * OCF_CLK_MHZ;
    localparam int OCF_DLY2_CYC = OCF_DLY2_US * OCF_CLK_MHZ;
    localparam int OCF_DLY3_CYC = OCF_DLY3_US * OCF_CLK_MHZ;
    localparam int OCF_HICCUP_CYC = OCF_HICCUP_MS * 1000 * OCF_CLK_MHZ;
    localparam int OCF_TMR_W = 24;
    // ==========================================
    // Fault state machine
    typedef enum logic [2:0]
    {
        OCF_ST_OFF = 3'h0,
        OCF_ST_RUN = 3'h1,
        OCF_ST_QUALIFY = 3'h2,
        OCF_ST_LATCHED = 3'h3,
        OCF_ST_HICCUP = 3'h4
    } ocf_state_t;
endpackage : ocf_pkg

//--- design/ocf_tmr_if.sv
`timescale 1ns/1ns
interface ocf_tmr_if;
    import ocf_pkg::*;
    logic start;
    logic clear;
    logic [OCF_TMR_W-1:0] load;
    logic done;
    modport ctl (output start, output clear, output load, input done);
    modport tmr (input start, input clear, input load, output done);
endinterface : ocf_tmr_if

//--- design/ocf_timer.sv
`timescale 1ns/1ns
module ocf_timer
    import ocf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    ocf_tmr_if.tmr t
);
    logic [OCF_TMR_W-1:0] cnt_reg;
    logic run_reg;
    logic done_reg;

    // ==========================================
    // Down counter, done pulses once on expiry
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (t.clear)
            begin
                cnt_reg <= '0;
                run_reg <= 1'b0;
            end
            else if (t.start)
            begin
                cnt_reg <= t.load;
                run_reg <= 1'b1;
            end
            else if (run_reg)
            begin
                if (cnt_reg <= OCF_TMR_W'(1))
                begin
                    run_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
                else
                begin
                    cnt_reg <= cnt_reg - OCF_TMR_W'(1);
                end
            end
        end
    end

    assign t.done = done_reg;
endmodule : ocf_timer

//--- design/ocf_fault_resp.sv
`timescale 1ns/1ns
module ocf_fault_resp
    import ocf_pkg::*;
#(
    parameter int QUAL_CYC_64US = OCF_DLY2_CYC,
    parameter int QUAL_CYC_256US = OCF_DLY3_CYC,
    parameter int HICCUP_CYC = OCF_HICCUP_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command port
    input wire logic cmd_rd,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ack,
    output logic cmd_nack,
    output logic [15:0] cmd_rdata,
    output logic invalid_data,
    // Mirror of undervoltage response
    input wire logic uv_resp_load,
    input wire logic [7:0] uv_resp_value,
    input wire logic nvm_restore,
    input wire logic nvm_retry_bit_in,
    output logic nvm_retry_bit,
    // Converter
    input wire logic conv_en,
    input wire logic in_current_limit,
    input wire logic uv_detected,
    input wire logic [5:0] avg_current,
    input wire logic clear_faults,
    output logic conv_run,
    // Status
    output logic sts_byte_oc_fault,
    output logic sts_word_iout,
    output logic sts_iout_overcurrent_undervolt_flag,
    output logic alert_n,
    output logic oc_warn
);
    ocf_tmr_if tif();
    ocf_state_t state_reg;
    logic [7:0] oc_lowvolt_fault_action_reg;
    logic [5:0] avg_current_warn_threshold_reg;
    logic fault_now;
    logic fault_set;
    logic lowvolt_fault_not_ignored;
    logic [2:0] lowvolt_retry_select;
    logic [1:0] lowvolt_qualify_delay;

    ocf_timer u_timer
    (
        .clk(clk),
        .arst_n(arst_n),
        .t(tif)
    );

    function automatic logic [OCF_TMR_W-1:0] qual_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: qual_cycles = OCF_TMR_W'(OCF_DLY0_CYC);
            2'h1: qual_cycles = OCF_TMR_W'(OCF_DLY1_CYC);
            2'h2: qual_cycles = OCF_TMR_W'(QUAL_CYC_64US);
            default: qual_cycles = OCF_TMR_W'(QUAL_CYC_256US);
        endcase
    endfunction : qual_cycles

    function automatic logic retry_ok(input logic [2:0] r);
        retry_ok = (r == OCF_RETRY_LATCH) || (r == OCF_RETRY_HICCUP);
    endfunction : retry_ok

    assign fault_now = in_current_limit && uv_detected;
    assign lowvolt_fault_not_ignored = oc_lowvolt_fault_action_reg[OCF_BIT_NOT_IGNORED];
    assign lowvolt_retry_select = oc_lowvolt_fault_action_reg[OCF_BIT_RETRY_HI:OCF_BIT_RETRY_LO];
    assign lowvolt_qualify_delay = oc_lowvolt_fault_action_reg[OCF_BIT_DELAY_HI-1:0];

    // ==========================================
    // Mirrored action register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            oc_lowvolt_fault_action_reg <= OCF_LV_ACTION_RST;
        end
        else if (nvm_restore)
        begin
            oc_lowvolt_fault_action_reg[OCF_BIT_RETRY_HI:OCF_BIT_RETRY_LO] <=
                {3{nvm_retry_bit_in}};
        end
        else if (uv_resp_load && retry_ok(uv_resp_value[5:3]))
        begin
            oc_lowvolt_fault_action_reg <=
                {1'b0, uv_resp_value[6:3], 1'b0, uv_resp_value[1:0]};
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nvm_retry_bit <= OCF_LV_ACTION_RST[OCF_BIT_RETRY_HI];
        end
        else
        begin
            nvm_retry_bit <= oc_lowvolt_fault_action_reg[OCF_BIT_RETRY_HI];
        end
    end

    // ==========================================
    // Command port
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_ack <= 1'b0;
            cmd_nack <= 1'b0;
            cmd_rdata <= 16'h0000;
            invalid_data <= 1'b0;
            avg_current_warn_threshold_reg <= OCF_WARN_MANT_RST;
        end
        else
        begin
            cmd_ack <= 1'b0;
            cmd_nack <= 1'b0;
            invalid_data <= 1'b0;
            if (uv_resp_load && !retry_ok(uv_resp_value[5:3]))
            begin
                invalid_data <= 1'b1;
            end
            if (cmd_rd)
            begin
                cmd_rdata <= 16'h0000;
                if (cmd_code == OCF_CMD_LV_ACTION)
                begin
                    cmd_ack <= 1'b1;
                    cmd_rdata <= {8'h00, oc_lowvolt_fault_action_reg};
                end
                else if (cmd_code == OCF_CMD_WARN_THR)
                begin
                    cmd_ack <= 1'b1;
                    cmd_rdata <= {10'h000, avg_current_warn_threshold_reg};
                end
                else
                begin
                    cmd_nack <= 1'b1;
                end
            end
            else if (cmd_wr)
            begin
                if (cmd_code == OCF_CMD_WARN_THR && cmd_wdata[15:6] == 10'h000)
                begin
                    cmd_ack <= 1'b1;
                    avg_current_warn_threshold_reg <= cmd_wdata[OCF_WARN_MANT_W-1:0];
                end
                else
                begin
                    cmd_nack <= 1'b1;
                    invalid_data <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Fault sequencing
    always_comb
    begin
        tif.start = 1'b0;
        tif.clear = 1'b0;
        tif.load = qual_cycles(lowvolt_qualify_delay);
        fault_set = 1'b0;
        case (state_reg)
            OCF_ST_RUN:
            begin
                if (conv_en && fault_now && lowvolt_fault_not_ignored)
                begin
                    tif.start = 1'b1;
                end
            end
            OCF_ST_QUALIFY:
            begin
                if (!conv_en || !fault_now)
                begin
                    tif.clear = 1'b1;
                end
                else if (tif.done)
                begin
                    fault_set = 1'b1;
                    if (lowvolt_retry_select == OCF_RETRY_HICCUP)
                    begin
                        tif.start = 1'b1;
                        tif.load = OCF_TMR_W'(HICCUP_CYC);
                    end
                end
            end
            OCF_ST_HICCUP:
            begin
                tif.clear = !conv_en;
            end
            default:
            begin
                tif.clear = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= OCF_ST_OFF;
            conv_run <= 1'b0;
        end
        else
        begin
            case (state_reg)
                OCF_ST_OFF:
                begin
                    if (conv_en)
                    begin
                        state_reg <= OCF_ST_RUN;
                        conv_run <= 1'b1;
                    end
                end
                OCF_ST_RUN:
                begin
                    if (!conv_en)
                    begin
                        state_reg <= OCF_ST_OFF;
                        conv_run <= 1'b0;
                    end
                    else if (tif.start)
                    begin
                        state_reg <= OCF_ST_QUALIFY;
                    end
                end
                OCF_ST_QUALIFY:
                begin
                    if (!conv_en)
                    begin
                        state_reg <= OCF_ST_OFF;
                        conv_run <= 1'b0;
                    end
                    else if (tif.clear)
                    begin
                        state_reg <= OCF_ST_RUN;
                    end
                    else if (fault_set)
                    begin
                        conv_run <= 1'b0;
                        state_reg <= (lowvolt_retry_select == OCF_RETRY_HICCUP) ? OCF_ST_HICCUP
                            : OCF_ST_LATCHED;
                    end
                end
                OCF_ST_LATCHED:
                begin
                    if (!conv_en)
                    begin
                        state_reg <= OCF_ST_OFF;
                    end
                end
                OCF_ST_HICCUP:
                begin
                    if (!conv_en)
                    begin
                        state_reg <= OCF_ST_OFF;
                    end
                    else if (tif.done)
                    begin
                        state_reg <= OCF_ST_RUN;
                        conv_run <= 1'b1;
                    end
                end
                default:
                begin
                    state_reg <= OCF_ST_OFF;
                    conv_run <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // Status flags and alert, set wins over clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sts_byte_oc_fault <= 1'b0;
            sts_word_iout <= 1'b0;
            sts_iout_overcurrent_undervolt_flag <= 1'b0;
            alert_n <= 1'b1;
        end
        else if (fault_set)
        begin
            sts_byte_oc_fault <= 1'b1;
            sts_word_iout <= 1'b1;
            sts_iout_overcurrent_undervolt_flag <= 1'b1;
            alert_n <= 1'b0;
        end
        else if (clear_faults)
        begin
            sts_byte_oc_fault <= 1'b0;
            sts_word_iout <= 1'b0;
            sts_iout_overcurrent_undervolt_flag <= 1'b0;
            alert_n <= 1'b1;
        end
    end

    // ==========================================
    // Average current warning
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            oc_warn <= 1'b0;
        end
        else
        begin
            oc_warn <= (avg_current >= avg_current_warn_threshold_reg);
        end
    end
endmodule : ocf_fault_resp

//--- testbench/ocf_fault_resp_chk.sv
`timescale 1ns/1ns
// ====
// Port checker
module ocf_fault_resp_chk
    import ocf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command port
    input wire logic cmd_rd,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_ack,
    input wire logic cmd_nack,
    input wire logic [15:0] cmd_rdata,
    input wire logic invalid_data,
    // Mirror and converter
    input wire logic nvm_restore,
    input wire logic nvm_retry_bit_in,
    input wire logic nvm_retry_bit,
    input wire logic in_current_limit,
    input wire logic uv_detected,
    input wire logic conv_run,
    // Status
    input wire logic sts_byte_oc_fault,
    input wire logic sts_word_iout,
    input wire logic sts_iout_overcurrent_undervolt_flag,
    input wire logic alert_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    answer_once_a: assert property (
        (cmd_rd || cmd_wr) |=> (cmd_ack ^ cmd_nack))
        else $error("request not answered exactly once");
    write_refused_a: assert property (
        (cmd_wr && !cmd_rd && cmd_code == OCF_CMD_LV_ACTION) |=> cmd_nack && invalid_data)
        else $error("write to action byte not refused");
    zero_bits_a: assert property (
        (cmd_rd && cmd_code == OCF_CMD_LV_ACTION) |=> cmd_rdata[15:7] == 9'h0 && !cmd_rdata[2])
        else $error("action byte fixed bits not zero");
    retry_equal_a: assert property (
        (cmd_rd && cmd_code == OCF_CMD_LV_ACTION) |=> cmd_rdata[5:3] inside {3'h0, 3'h7})
        else $error("retry bits differ");
    flags_together_a: assert property (
        $rose(sts_iout_overcurrent_undervolt_flag) |-> sts_byte_oc_fault && sts_word_iout
        && !alert_n)
        else $error("status flags or alert missing");
    flag_cause_a: assert property (
        $rose(sts_iout_overcurrent_undervolt_flag) |-> $past(in_current_limit && uv_detected))
        else $error("flag set without fault");
    run_stops_a: assert property (
        $rose(sts_iout_overcurrent_undervolt_flag) |-> !conv_run)
        else $error("converter still running at fault");
    restore_copy_a: assert property (
        nvm_restore |-> ##2 nvm_retry_bit == $past(nvm_retry_bit_in, 2))
        else $error("restored retry bit wrong");

    cover property ($rose(sts_iout_overcurrent_undervolt_flag));
    cover property (invalid_data);
    cover property ($rose(conv_run));
endmodule : ocf_fault_resp_chk

bind ocf_fault_resp ocf_fault_resp_chk ocf_fault_resp_chk_inst (.clk, .arst_n, .cmd_rd,
    .cmd_wr, .cmd_code, .cmd_ack, .cmd_nack, .cmd_rdata, .invalid_data, .nvm_restore,
    .nvm_retry_bit_in, .nvm_retry_bit, .in_current_limit, .uv_detected, .conv_run,
    .sts_byte_oc_fault, .sts_word_iout, .sts_iout_overcurrent_undervolt_flag, .alert_n);

//--- testbench/ocf_host.sv
`timescale 1ns/1ns
// ====
// Host command model
module ocf_host
(
    // Clock
    input wire logic clk,
    // Request
    output logic cmd_rd,
    output logic cmd_wr,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    // Answer
    input wire logic cmd_ack,
    input wire logic cmd_nack,
    input wire logic [15:0] cmd_rdata,
    input wire logic invalid_data
);
    initial
    begin
        cmd_rd = 1'b0;
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // One-cycle request, answer caught in a bounded window
    task automatic xfer(input logic rd, input logic [7:0] code, input logic [15:0] wd,
        output logic [2:0] resp, output logic [15:0] rdat);
        resp = 3'h0;
        rdat = 16'h0000;
        cmd_rd = rd;
        cmd_wr = !rd;
        cmd_code = code;
        cmd_wdata = wd;
        @(negedge clk);
        cmd_rd = 1'b0;
        cmd_wr = 1'b0;
        cmd_wdata = ~wd;
        for (int i = 0; i < 3; i++)
        begin
            if (resp == 3'h0 && (cmd_ack || cmd_nack))
            begin
                resp = {cmd_ack, cmd_nack, invalid_data};
                rdat = cmd_rdata;
            end
            @(negedge clk);
        end
    endtask : xfer
endmodule : ocf_host

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import ocf_pkg::*;
    // ====
    // Signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_rd, cmd_wr, cmd_ack, cmd_nack, invalid_data, nvm_retry_bit, conv_run;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata;
    logic uv_resp_load = 1'b0;
    logic [7:0] uv_resp_value = 8'h00;
    logic nvm_restore = 1'b0;
    logic nvm_retry_bit_in = 1'b1;
    logic conv_en = 1'b0;
    logic in_current_limit = 1'b0;
    logic uv_detected = 1'b0;
    logic [5:0] avg_current = 6'h00;
    logic clear_faults = 1'b0;
    logic sts_byte_oc_fault, sts_word_iout, sts_iout_overcurrent_undervolt_flag;
    logic alert_n, oc_warn;
    int errors = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    ocf_fault_resp #(.QUAL_CYC_64US(40), .QUAL_CYC_256US(60), .HICCUP_CYC(100))
        ocf_fault_resp_inst (.clk, .arst_n, .cmd_rd, .cmd_wr, .cmd_code, .cmd_wdata,
        .cmd_ack, .cmd_nack, .cmd_rdata, .invalid_data, .uv_resp_load, .uv_resp_value,
        .nvm_restore, .nvm_retry_bit_in, .nvm_retry_bit, .conv_en, .in_current_limit,
        .uv_detected, .avg_current, .clear_faults, .conv_run, .sts_byte_oc_fault,
        .sts_word_iout, .sts_iout_overcurrent_undervolt_flag, .alert_n, .oc_warn);
    ocf_host ocf_host_inst (.clk, .cmd_rd, .cmd_wr, .cmd_code, .cmd_wdata, .cmd_ack,
        .cmd_nack, .cmd_rdata, .invalid_data);

    // ====
    // Helpers
    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        n_compared++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("unexpected at %0t: %s took %0d", $time, what, got);
        end
    endtask : chk_rng

    task automatic wait_run(input logic lvl, input int lim, output int n);
        n = 0;
        while (conv_run !== lvl)
        begin
            @(negedge clk);
            n++;
            if (n > lim)
            begin
                errors++;
                $display("unexpected at %0t: run output stuck", $time);
                final_report();
            end
        end
    endtask : wait_run

    task automatic cmd(input logic rd, input logic [7:0] code, input logic [15:0] wd,
        input logic [2:0] exp, input logic [15:0] exp_d);
        logic [2:0] r;
        logic [15:0] d;
        ocf_host_inst.xfer(rd, code, wd, r, d);
        chk({13'h0, r}, {13'h0, exp}, "answer");
        if (rd && exp[2])
            chk(d, exp_d, "read data");
    endtask : cmd

    task automatic load(input logic [7:0] v, output logic inv);
        uv_resp_value = v;
        uv_resp_load = 1'b1;
        @(negedge clk);
        uv_resp_load = 1'b0;
        inv = invalid_data;
        @(negedge clk);
        inv = inv | invalid_data;
    endtask : load

    task automatic fault(input logic f);
        in_current_limit = f;
        uv_detected = f;
    endtask : fault

    task automatic clear();
        clear_faults = 1'b1;
        @(negedge clk);
        clear_faults = 1'b0;
        @(negedge clk);
        chk({15'h0, alert_n}, 16'h1, "alert released");
    endtask : clear

    // ====
    // Scenarios
    task automatic t_regs();
        cmd(1'b1, OCF_CMD_LV_ACTION, 16'h0, 3'h4, 16'h0040);
        cmd(1'b0, OCF_CMD_LV_ACTION, 16'h0000, 3'h3, 16'h0);
        cmd(1'b1, OCF_CMD_WARN_THR, 16'h0, 3'h4, 16'h003f);
        cmd(1'b0, OCF_CMD_WARN_THR, 16'h0015, 3'h4, 16'h0);
        cmd(1'b0, OCF_CMD_WARN_THR, 16'h0055, 3'h3, 16'h0);
        cmd(1'b1, OCF_CMD_WARN_THR, 16'h0, 3'h4, 16'h0015);
        cmd(1'b1, 8'h48, 16'h0, 3'h2, 16'h0);
        avg_current = 6'h14;
        repeat (3) @(negedge clk);
        chk({15'h0, oc_warn}, 16'h0, "warn below");
        avg_current = 6'h15;
        repeat (3) @(negedge clk);
        chk({15'h0, oc_warn}, 16'h1, "warn at level");
        $display("test registers done");
    endtask : t_regs

    task automatic t_mirror();
        logic inv;
        load(8'hff, inv);
        chk({15'h0, inv}, 16'h0, "load accepted");
        cmd(1'b1, OCF_CMD_LV_ACTION, 16'h0, 3'h4, 16'h007b);
        chk({15'h0, nvm_retry_bit}, 16'h1, "stored bit");
        load(8'h50, inv);
        chk({15'h0, inv}, 16'h1, "load rejected");
        cmd(1'b1, OCF_CMD_LV_ACTION, 16'h0, 3'h4, 16'h007b);
        nvm_retry_bit_in = 1'b0;
        nvm_restore = 1'b1;
        @(negedge clk);
        nvm_restore = 1'b0;
        repeat (3) @(negedge clk);
        cmd(1'b1, OCF_CMD_LV_ACTION, 16'h0, 3'h4, 16'h0043);
        $display("test mirror done");
    endtask : t_mirror

    task automatic t_short();
        logic inv;
        load(8'h42, inv);
        repeat (2)
        begin
            fault(1'b1);
            repeat (30) @(negedge clk);
            fault(1'b0);
            repeat (5) @(negedge clk);
        end
        chk({15'h0, conv_run}, 16'h1, "run kept");
        chk({15'h0, sts_word_iout}, 16'h0, "no flag");
        load(8'h02, inv);
        fault(1'b1);
        repeat (150) @(negedge clk);
        chk({15'h0, conv_run}, 16'h1, "ignored run");
        chk({15'h0, sts_iout_overcurrent_undervolt_flag}, 16'h0, "ignored flag");
        fault(1'b0);
        $display("test short and ignored faults done");
    endtask : t_short

    task automatic t_latch(input logic [7:0] act, input int n);
        int c;
        logic inv;
        load(act, inv);
        fault(1'b1);
        wait_run(1'b0, n + 10, c);
        chk_rng(c, n, n + 4, "qualify delay");
        chk({12'h0, sts_byte_oc_fault, sts_word_iout, sts_iout_overcurrent_undervolt_flag,
            alert_n}, 16'he, "flags and alert");
        fault(1'b0);
        repeat (150) @(negedge clk);
        chk({15'h0, conv_run}, 16'h0, "latched off");
        conv_en = 1'b0;
        repeat (3) @(negedge clk);
        conv_en = 1'b1;
        wait_run(1'b1, 10, c);
        clear();
        $display("test latch-off done");
    endtask : t_latch

    task automatic t_hiccup();
        int c;
        logic inv;
        load(8'h7b, inv);
        fault(1'b1);
        wait_run(1'b0, 70, c);
        chk_rng(c, 60, 64, "qualify delay");
        repeat (2)
        begin
            wait_run(1'b1, 120, c);
            chk_rng(c, 100, 105, "hiccup period");
            wait_run(1'b0, 70, c);
            chk_rng(c, 60, 64, "requalify delay");
        end
        fault(1'b0);
        wait_run(1'b1, 120, c);
        clear();
        $display("test hiccup done");
    endtask : t_hiccup

    // ====
    // Main sequence
    initial
    begin
        int c;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        conv_en = 1'b1;
        wait_run(1'b1, 10, c);
        t_regs();
        t_mirror();
        t_short();
        t_latch(8'h40, OCF_DLY0_CYC);
        t_latch(8'h41, OCF_DLY1_CYC);
        t_hiccup();
        final_report();
    end
endmodule : tb_top
